//--- hdl/lig_consts.svh
// Constants for the load instruction group decoder.
`ifndef LIG_CONSTS_SVH
`define LIG_CONSTS_SVH
// ****************************************
// Opcodes, full byte
// ****************************************
`define LIG_OP_IND_SRC 8'hC_7
`define LIG_OP_IND_DST 8'hD_7
`define LIG_OP_RR 8'hE_4
`define LIG_OP_RIR 8'hE_5
`define LIG_OP_RIM 8'hE_6
`define LIG_OP_IRIM 8'hD_6
`define LIG_OP_IRR 8'hF_5
`define LIG_OP_IDX_SRC 8'h8_7
`define LIG_OP_IDX_DST 8'h9_7
`define LIG_OP_BIT 8'h4_7
`define LIG_OP_MEM_RD 8'hC_3
`define LIG_OP_MEM_WR 8'hD_3
`define LIG_OP_XS_RD 8'hE_7
`define LIG_OP_XS_WR 8'hF_7
`define LIG_OP_XL_RD 8'hA_7
`define LIG_OP_XL_WR 8'hB_7
// ****************************************
// Opcode low nibbles of the r-form loads
// ****************************************
`define LIG_NIB_IMM 4'hC
`define LIG_NIB_RSRC 4'h8
`define LIG_NIB_RDST 4'h9
// ****************************************
// Pair codes reserved for direct address
// ****************************************
`define LIG_PAIR_DA_PROG 4'h0
`define LIG_PAIR_DA_DATA 4'h1
// ****************************************
// Working register window base (high nibble)
// ****************************************
`define LIG_WORK_BASE 4'hC
// ****************************************
// Cycle counts
// ****************************************
`define LIG_CYC_2B 4'h4
`define LIG_CYC_3B 4'h6
`define LIG_CYC_MEM2 4'hA
`define LIG_CYC_MEM3 4'hC
`define LIG_CYC_MEM4 4'hE
`endif

//--- hdl/lig_pkg.sv
// Types shared by the load instruction group decoder.
package lig_pkg;
  // Register file access request
  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [7:0] data;
  } lig_rf_req_t;
  // External memory access request
  typedef struct packed {
    logic en;
    logic wr;
    logic dataSpace;
    logic [15:0] addr;
    logic [7:0] data;
  } lig_mem_req_t;
  // Decoded instruction class
  typedef enum logic [3:0] {
    LIG_K_NONE, LIG_K_MOVE, LIG_K_BIT_LD, LIG_K_BIT_ST,
    LIG_K_MEM_RD, LIG_K_MEM_WR
  } lig_kind_t;
endpackage : lig_pkg

//--- hdl/lig_decode.sv
// Combinational decode of a load-group opcode into length and cycles.
`timescale 1ns/1ns
`include "lig_consts.svh"
module lig_decode
  import lig_pkg::*;
(
  input wire logic [7:0] opcode,
  output logic legal,
  output logic [2:0] numBytes,
  output logic [3:0] numCycles
);
  // ****************************************
  // Length and cycle table
  // ****************************************
  // Unknown opcodes report illegal so the sequencer refuses them
  always_comb begin
    legal = 1'b1;
    numBytes = 3'd2;
    numCycles = `LIG_CYC_2B;
    if (opcode[3:0] == `LIG_NIB_IMM || opcode[3:0] == `LIG_NIB_RSRC ||
        opcode[3:0] == `LIG_NIB_RDST) begin
      numBytes = 3'd2;
      numCycles = `LIG_CYC_2B;
    end else if (opcode == `LIG_OP_IND_SRC || opcode == `LIG_OP_IND_DST) begin
      numBytes = 3'd2;
      numCycles = `LIG_CYC_2B;
    end else if (opcode == `LIG_OP_RR || opcode == `LIG_OP_RIR ||
                 opcode == `LIG_OP_RIM || opcode == `LIG_OP_IRIM ||
                 opcode == `LIG_OP_IRR || opcode == `LIG_OP_IDX_SRC ||
                 opcode == `LIG_OP_IDX_DST || opcode == `LIG_OP_BIT) begin
      numBytes = 3'd3;
      numCycles = `LIG_CYC_3B;
    end else if (opcode == `LIG_OP_MEM_RD || opcode == `LIG_OP_MEM_WR) begin
      numBytes = 3'd2;
      numCycles = `LIG_CYC_MEM2;
    end else if (opcode == `LIG_OP_XS_RD || opcode == `LIG_OP_XS_WR) begin
      numBytes = 3'd3;
      numCycles = `LIG_CYC_MEM3;
    end else if (opcode == `LIG_OP_XL_RD || opcode == `LIG_OP_XL_WR) begin
      numBytes = 3'd4;
      numCycles = `LIG_CYC_MEM4;
    end else begin
      legal = 1'b0;
    end
  end
endmodule : lig_decode

//--- hdl/lig_load_group.sv
// Sequencer and datapath for the load instruction group.
`timescale 1ns/1ns
`include "lig_consts.svh"
module lig_load_group
  import lig_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic instStart,
  input wire logic [7:0] instByte0,
  input wire logic [7:0] instByte1,
  input wire logic [7:0] instByte2,
  input wire logic [7:0] instByte3,
  input wire logic [7:0] rfRdData,
  input wire logic [7:0] memRdData,
  output logic busy,
  output logic done,
  output logic illegal,
  output logic [2:0] instLen,
  output logic [7:0] rfRdAddr,
  output lig_rf_req_t rfWr,
  output lig_mem_req_t memReq,
  output logic flagsWrEn
);
  // ****************************************
  // Sequencer states
  // ****************************************
  // Register file and memory are read with one-cycle latency
  typedef enum logic [2:0] {
    LIG_IDLE, LIG_RD_A, LIG_RD_B, LIG_RD_C, LIG_EXEC, LIG_WAIT
  } lig_state_t;

  lig_state_t state_q, state_d;
  logic [7:0] op_q, op_d; // Latched opcode
  logic [7:0] b1_q, b1_d; // Second byte
  logic [7:0] b2_q, b2_d; // Third byte
  logic [7:0] b3_q, b3_d; // Fourth byte
  logic [7:0] tmpA_q, tmpA_d; // First value read
  logic [7:0] tmpB_q, tmpB_d; // Second value read
  logic [3:0] cnt_q, cnt_d; // Cycles left in instruction
  lig_kind_t kind_q, kind_d;
  logic busy_q, busy_d;
  logic done_q, done_d;
  logic ill_q, ill_d;
  logic [2:0] len_q, len_d;
  logic [7:0] rdAddr_q, rdAddr_d;
  lig_rf_req_t rfWr_q, rfWr_d;
  lig_mem_req_t mem_q, mem_d;
  logic memPend_q, memPend_d; // Memory read data due this cycle
  // Decoder outputs
  logic decLegal;
  logic [2:0] decBytes;
  logic [3:0] decCycles;

  // Working register nibble to full register address
  function automatic logic [7:0] workAddr(input logic [3:0] r);
    workAddr = {`LIG_WORK_BASE, r};
  endfunction : workAddr

  // Even-aligned pair address, lsb of field dropped
  function automatic logic [7:0] pairAddr(input logic [3:0] rr);
    pairAddr = {`LIG_WORK_BASE, rr[3:1], 1'b0};
  endfunction : pairAddr

  // ****************************************
  // Opcode length and cycle decode
  // ****************************************
  lig_decode uDecode (
    .opcode(instByte0),
    .legal(decLegal),
    .numBytes(decBytes),
    .numCycles(decCycles)
  );

  // ****************************************
  // Next-state logic
  // ****************************************
  // Reads walk one address per cycle; execution issues one register write or one memory request
  always_comb begin
    state_d = state_q;
    op_d = op_q;
    b1_d = b1_q;
    b2_d = b2_q;
    b3_d = b3_q;
    tmpA_d = tmpA_q;
    tmpB_d = tmpB_q;
    cnt_d = cnt_q;
    kind_d = kind_q;
    busy_d = busy_q;
    done_d = 1'b0;
    ill_d = 1'b0;
    len_d = len_q;
    rdAddr_d = rdAddr_q;
    rfWr_d = '0;
    mem_d = '0;
    memPend_d = mem_q.en && !mem_q.wr;
    if (cnt_q != 4'h0) begin
      cnt_d = cnt_q - 4'h1;
    end
    // Done follows the count alone; short forms write just after it
    if (busy_q && cnt_q == 4'h1) begin
      done_d = 1'b1;
      busy_d = 1'b0;
    end
    case (state_q)
      LIG_RD_A: begin
        // Second read address depends on form and operand bytes only
        state_d = LIG_RD_B;
        if (op_q == `LIG_OP_RIR || op_q == `LIG_OP_IND_SRC) begin
          rdAddr_d = 8'h0_0;
        end else if (op_q == `LIG_OP_IRR || op_q == `LIG_OP_RR) begin
          rdAddr_d = b2_q;
        end else if (op_q == `LIG_OP_BIT) begin
          rdAddr_d = b2_q;
        end else if (op_q == `LIG_OP_IND_DST) begin
          rdAddr_d = workAddr(b1_q[3:0]);
        end else if (op_q == `LIG_OP_IDX_DST) begin
          rdAddr_d = workAddr(b1_q[7:4]);
        end else if (kind_q == LIG_K_MEM_RD || kind_q == LIG_K_MEM_WR) begin
          rdAddr_d = pairAddr(b1_q[3:0]) | 8'h0_1;
        end
      end
      LIG_RD_B: begin
        tmpA_d = rfRdData;
        state_d = LIG_RD_C;
        // Indirect sources read through the pointer just fetched
        if (op_q == `LIG_OP_RIR || op_q == `LIG_OP_IND_SRC) begin
          rdAddr_d = rfRdData;
        end else if (op_q == `LIG_OP_IDX_SRC) begin
          rdAddr_d = rfRdData + b2_q;
        end else if (kind_q == LIG_K_MEM_RD || kind_q == LIG_K_MEM_WR) begin
          rdAddr_d = workAddr(b1_q[7:4]);
        end
      end
      LIG_RD_C: begin
        tmpB_d = rfRdData;
        state_d = LIG_EXEC;
      end
      LIG_EXEC: begin
        state_d = LIG_WAIT;
        rfWr_d.en = 1'b1;
        case (kind_q)
          LIG_K_MOVE: begin
            if (op_q[3:0] == `LIG_NIB_IMM) begin
              rfWr_d.addr = workAddr(op_q[7:4]);
              rfWr_d.data = b1_q;
            end else if (op_q[3:0] == `LIG_NIB_RSRC) begin
              rfWr_d.addr = workAddr(op_q[7:4]);
              rfWr_d.data = tmpA_q;
            end else if (op_q[3:0] == `LIG_NIB_RDST) begin
              rfWr_d.addr = b1_q;
              rfWr_d.data = tmpA_q;
            end else if (op_q == `LIG_OP_IND_SRC) begin
              rfWr_d.addr = workAddr(b1_q[7:4]);
              rfWr_d.data = rfRdData;
            end else if (op_q == `LIG_OP_IND_DST) begin
              rfWr_d.addr = tmpA_q;
              rfWr_d.data = tmpB_q;
            end else if (op_q == `LIG_OP_RR) begin
              rfWr_d.addr = b2_q;
              rfWr_d.data = tmpA_q;
            end else if (op_q == `LIG_OP_RIR) begin
              rfWr_d.addr = b2_q;
              rfWr_d.data = rfRdData;
            end else if (op_q == `LIG_OP_RIM) begin
              rfWr_d.addr = b1_q;
              rfWr_d.data = b2_q;
            end else if (op_q == `LIG_OP_IRIM) begin
              rfWr_d.addr = tmpA_q;
              rfWr_d.data = b2_q;
            end else if (op_q == `LIG_OP_IRR) begin
              rfWr_d.addr = tmpB_q;
              rfWr_d.data = tmpA_q;
            end else if (op_q == `LIG_OP_IDX_SRC) begin
              rfWr_d.addr = workAddr(b1_q[7:4]);
              rfWr_d.data = rfRdData;
            end else begin
              rfWr_d.addr = tmpA_q + b2_q;
              rfWr_d.data = tmpB_q;
            end
          end
          LIG_K_BIT_LD: begin
            rfWr_d.addr = workAddr(b1_q[7:4]);
            rfWr_d.data = {tmpA_q[7:1], tmpB_q[b1_q[3:1]]};
          end
          LIG_K_BIT_ST: begin
            rfWr_d.addr = b2_q;
            rfWr_d.data = tmpB_q;
            rfWr_d.data[b1_q[3:1]] = tmpA_q[0];
          end
          default: begin
            // Memory forms: pair gives high then low byte
            rfWr_d.en = 1'b0;
            mem_d.en = 1'b1;
            mem_d.wr = (kind_q == LIG_K_MEM_WR);
            mem_d.dataSpace = b1_q[0];
            if ((op_q == `LIG_OP_XL_RD || op_q == `LIG_OP_XL_WR) &&
                (b1_q[3:0] == `LIG_PAIR_DA_PROG ||
                 b1_q[3:0] == `LIG_PAIR_DA_DATA)) begin
              mem_d.addr = {b3_q, b2_q};
            end else if (op_q == `LIG_OP_XL_RD || op_q == `LIG_OP_XL_WR) begin
              mem_d.addr = {tmpA_q, tmpB_q} + {b3_q, b2_q};
            end else if (op_q == `LIG_OP_XS_RD || op_q == `LIG_OP_XS_WR) begin
              mem_d.addr = {tmpA_q, tmpB_q} + {8'h0_0, b2_q};
            end else begin
              mem_d.addr = {tmpA_q, tmpB_q};
            end
            mem_d.data = rfRdData;
          end
        endcase
      end
      default: begin
        // Idle and wait; read data lands the cycle after the request
        if (kind_q == LIG_K_MEM_RD && memPend_q) begin
          rfWr_d.en = 1'b1;
          rfWr_d.addr = workAddr(b1_q[7:4]);
          rfWr_d.data = memRdData;
        end
        if (cnt_q <= 4'h1) begin
          state_d = LIG_IDLE;
        end
      end
    endcase
    // A start is taken whenever busy is low, even while a write drains
    if (instStart && !busy_q) begin
      if (!decLegal) begin
        // Foreign opcodes are refused, nothing changes
        ill_d = 1'b1;
        done_d = 1'b1;
      end else begin
        op_d = instByte0;
        b1_d = instByte1;
        b2_d = instByte2;
        b3_d = instByte3;
        len_d = decBytes;
        cnt_d = decCycles - 4'h1;
        busy_d = 1'b1;
        state_d = LIG_RD_A;
        kind_d = LIG_K_MOVE;
        // First read address per form
        if (instByte0[3:0] == `LIG_NIB_IMM) begin
          rdAddr_d = instByte1;
        end else if (instByte0[3:0] == `LIG_NIB_RSRC) begin
          rdAddr_d = instByte1;
        end else if (instByte0[3:0] == `LIG_NIB_RDST) begin
          rdAddr_d = workAddr(instByte0[7:4]);
        end else if (instByte0 == `LIG_OP_IND_SRC) begin
          rdAddr_d = workAddr(instByte1[3:0]);
        end else if (instByte0 == `LIG_OP_IND_DST) begin
          rdAddr_d = workAddr(instByte1[7:4]);
        end else if (instByte0 == `LIG_OP_RR ||
                     instByte0 == `LIG_OP_RIR) begin
          rdAddr_d = instByte1;
        end else if (instByte0 == `LIG_OP_RIM ||
                     instByte0 == `LIG_OP_IRIM) begin
          rdAddr_d = instByte1;
        end else if (instByte0 == `LIG_OP_IRR) begin
          rdAddr_d = instByte1;
        end else if (instByte0 == `LIG_OP_IDX_SRC ||
                     instByte0 == `LIG_OP_IDX_DST) begin
          rdAddr_d = workAddr(instByte1[3:0]);
        end else if (instByte0 == `LIG_OP_BIT) begin
          kind_d = instByte1[0] ? LIG_K_BIT_ST : LIG_K_BIT_LD;
          rdAddr_d = workAddr(instByte1[7:4]);
        end else begin
          kind_d = (instByte0[4] == 1'b0) ? LIG_K_MEM_RD : LIG_K_MEM_WR;
          rdAddr_d = pairAddr(instByte1[3:0]);
        end
      end
    end
  end

  // ****************************************
  // State registers
  // ****************************************
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= LIG_IDLE;
      op_q <= 8'h0_0;
      b1_q <= 8'h0_0;
      b2_q <= 8'h0_0;
      b3_q <= 8'h0_0;
      tmpA_q <= 8'h0_0;
      tmpB_q <= 8'h0_0;
      cnt_q <= 4'h0;
      kind_q <= LIG_K_NONE;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      ill_q <= 1'b0;
      len_q <= 3'h0;
      rdAddr_q <= 8'h0_0;
      rfWr_q <= '0;
      mem_q <= '0;
      memPend_q <= 1'b0;
    end else begin
      state_q <= state_d;
      op_q <= op_d;
      b1_q <= b1_d;
      b2_q <= b2_d;
      b3_q <= b3_d;
      tmpA_q <= tmpA_d;
      tmpB_q <= tmpB_d;
      cnt_q <= cnt_d;
      kind_q <= kind_d;
      busy_q <= busy_d;
      done_q <= done_d;
      ill_q <= ill_d;
      len_q <= len_d;
      rdAddr_q <= rdAddr_d;
      rfWr_q <= rfWr_d;
      mem_q <= mem_d;
      memPend_q <= memPend_d;
    end
  end

  // ****************************************
  // Outputs from flip-flops; flagsWrEn tied low
  // ****************************************
  assign busy = busy_q;
  assign done = done_q;
  assign illegal = ill_q;
  assign instLen = len_q;
  assign rfRdAddr = rdAddr_q;
  assign rfWr = rfWr_q;
  assign memReq = mem_q;
  assign flagsWrEn = 1'b0;
endmodule : lig_load_group

//--- tb/lig_far_model.sv
// Register file and memory model facing the load group.
`timescale 1ns/1ns
module lig_far_model
  import lig_pkg::*;
(
  input wire logic core_clk,
  input wire logic [7:0] rfRdAddr,
  input wire lig_rf_req_t rfWr,
  input wire lig_mem_req_t memReq,
  output logic [7:0] rfRdData,
  output logic [7:0] memRdData
);
  // ****************************************
  // Storage, preloaded by the bench
  // ****************************************
  logic [7:0] regs [0:255]; // Register file
  logic [7:0] progMem [0:65535]; // Program memory
  logic [7:0] dataMem [0:65535]; // External data memory
  initial begin
    rfRdData = 8'h00;
    memRdData = 8'h00;
  end
  // Register file: read data one cycle after the address
  always @(posedge core_clk) begin
    rfRdData <= regs[rfRdAddr];
    if (rfWr.en) begin
      regs[rfWr.addr] <= rfWr.data;
    end
  end
  // Read data is valid only the cycle after a read; toggles otherwise
  // so a late sample never passes by luck
  always @(posedge core_clk) begin
    if (memReq.en && !memReq.wr) begin
      memRdData <= memReq.dataSpace ? dataMem[memReq.addr]
                                    : progMem[memReq.addr];
    end else begin
      memRdData <= ~memRdData;
    end
    // Writes land in the space that the request names
    if (memReq.en && memReq.wr && memReq.dataSpace) begin
      dataMem[memReq.addr] <= memReq.data;
    end
    if (memReq.en && memReq.wr && !memReq.dataSpace) begin
      progMem[memReq.addr] <= memReq.data;
    end
  end
endmodule : lig_far_model

//--- tb/lig_load_group_properties.sv
// Concurrent checks on the load group ports.
`timescale 1ns/1ns
module lig_load_group_properties
  import lig_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic instStart,
  input wire logic [7:0] instByte0,
  input wire logic [7:0] instByte1,
  input wire logic [7:0] instByte2,
  input wire logic [7:0] instByte3,
  input wire logic busy,
  input wire logic done,
  input wire logic illegal,
  input wire lig_mem_req_t memReq,
  input wire logic flagsWrEn
);
  // ****************************************
  // Operand capture
  // ****************************************
  logic [7:0] opQ; // Opcode of the running instruction
  logic [7:0] pairQ; // Second byte, holds the pair field
  logic [15:0] daQ; // Absolute address, high byte last
  wire logic opTwo = instByte0[3:0] inside {4'hC, 4'h8, 4'h9} ||
    instByte0 inside {8'hC7, 8'hD7};
  wire logic opThree = instByte0 inside {8'hE4, 8'hE5, 8'hE6,
    8'hD6, 8'hF5, 8'h87, 8'h97};
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // A start that the idle block accepts
  sequence sTake;
    instStart && !busy;
  endsequence
  // Latch operands at the accepting edge
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      opQ <= 8'h00;
      pairQ <= 8'h00;
      daQ <= 16'h0000;
    end else if (instStart && !busy) begin
      opQ <= instByte0;
      pairQ <= instByte1;
      daQ <= {instByte3, instByte2};
    end
  end
  a_flags_untouched: assert property (flagsWrEn == 1'b0)
    else $error("flag write raised");
  a_two_byte_time: assert property (sTake ##0 opTwo |-> ##4 done)
    else $error("short load time wrong");
  a_three_byte_time: assert property (
    sTake ##0 opThree |-> ##6 done) else $error("long load time wrong");
  a_bit_load_time: assert property (
    sTake ##0 instByte0 == 8'h47 |-> ##6 done) else $error("bit load time");
  a_pair_ind_time: assert property (
    sTake ##0 instByte0 inside {8'hC3, 8'hD3} |-> ##10 done)
    else $error("pair indirect time");
  a_short_off_time: assert property (
    sTake ##0 instByte0 inside {8'hE7, 8'hF7} |-> ##12 done)
    else $error("short offset time");
  a_long_off_time: assert property (
    sTake ##0 instByte0 inside {8'hA7, 8'hB7} |-> ##14 done)
    else $error("long offset time");
  a_illegal_pulse: assert property (
    sTake ##0 instByte0 == 8'hFF |-> ##1 (done && illegal))
    else $error("illegal not flagged");
  a_space_select: assert property (
    memReq.en |-> memReq.dataSpace == pairQ[0]) else $error("wrong space");
  a_mem_direction: assert property (
    memReq.en |-> memReq.wr == (opQ inside {8'hD3, 8'hF7, 8'hB7}))
    else $error("wrong memory direction");
  a_direct_addr: assert property (
    memReq.en && opQ inside {8'hA7, 8'hB7} && pairQ[3:1] == 3'h0
    |-> memReq.addr == daQ) else $error("direct address wrong");
endmodule : lig_load_group_properties
bind lig_load_group lig_load_group_properties chk_u (
  .core_clk(core_clk), .sys_rst(sys_rst), .instStart(instStart),
  .instByte0(instByte0), .instByte1(instByte1), .instByte2(instByte2),
  .instByte3(instByte3), .busy(busy), .done(done), .illegal(illegal),
  .memReq(memReq), .flagsWrEn(flagsWrEn)
);

//--- tb/load_instruction_group_decoder_tb_top.sv
// Self-checking bench for the load group.
`timescale 1ns/1ns
module load_instruction_group_decoder_tb_top
  import lig_pkg::*;
;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic instStart = 1'b0;
  logic [7:0] instByte0 = 8'h00;
  logic [7:0] instByte1 = 8'h00;
  logic [7:0] instByte2 = 8'h00;
  logic [7:0] instByte3 = 8'h00;
  logic [7:0] rfRdData, memRdData, rfRdAddr;
  logic busy, done, illegal, flagsWrEn, sawIllegal;
  logic [2:0] instLen;
  lig_rf_req_t rfWr;
  lig_mem_req_t memReq;
  int fails = 0;
  int testsRun = 0;
  int cycles = 0; // Hang guard
  always #4 core_clk = ~core_clk;
  lig_load_group dut_u (.core_clk(core_clk), .sys_rst(sys_rst),
    .instStart(instStart), .instByte0(instByte0), .instByte1(instByte1),
    .instByte2(instByte2), .instByte3(instByte3), .rfRdData(rfRdData),
    .memRdData(memRdData), .busy(busy), .done(done), .illegal(illegal),
    .instLen(instLen), .rfRdAddr(rfRdAddr), .rfWr(rfWr), .memReq(memReq),
    .flagsWrEn(flagsWrEn));
  lig_far_model far_u (.core_clk(core_clk), .rfRdAddr(rfRdAddr),
    .rfWr(rfWr), .memReq(memReq), .rfRdData(rfRdData),
    .memRdData(memRdData));
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic conclude();
    if (fails == 0 && testsRun > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : conclude
  task automatic checkV(input string what, input logic [15:0] expV,
    input logic [15:0] gotV);
    testsRun++;
    if (gotV !== expV) begin
      fails++;
      $display("MISMATCH %s exp %h got %h", what, expV, gotV);
    end
  endtask : checkV
  // Known register and memory contents before every instruction
  task automatic preset();
    far_u.regs[8'hC0] = 8'h01;
    far_u.regs[8'hC1] = 8'h0A;
    far_u.regs[8'hC2] = 8'h06;
    far_u.regs[8'hC4] = 8'h01;
    far_u.regs[8'hC5] = 8'h04;
    far_u.regs[8'h00] = 8'h01;
    far_u.regs[8'h01] = 8'h20;
    far_u.regs[8'h02] = 8'h02;
    far_u.regs[8'h31] = 8'h00;
    far_u.regs[8'h3A] = 8'hFF;
    far_u.progMem[16'h0104] = 8'h1A;
    far_u.progMem[16'h0105] = 8'h6D;
    far_u.progMem[16'h1104] = 8'h88;
    far_u.progMem[16'h1105] = 8'h00;
    far_u.dataMem[16'h0104] = 8'h2A;
    far_u.dataMem[16'h1104] = 8'h98;
    far_u.dataMem[16'h1105] = 8'h00;
  endtask : preset
  // Run one instruction; sel 0 register, 1 program, 2 data memory
  task automatic step(input logic [31:0] inst, input int cyc,
    input int sel, input logic [15:0] addr, input logic [7:0] expV);
    int n;
    logic [7:0] got;
    preset();
    instStart = 1'b1;
    {instByte0, instByte1, instByte2, instByte3} = inst;
    @(negedge core_clk);
    instStart = 1'b0;
    n = 1;
    while (done !== 1'b1 && n < 40) begin
      @(negedge core_clk);
      n++;
    end
    sawIllegal = illegal;
    checkV("cycles", 16'(cyc), 16'(n));
    if (cyc > 1) begin
      checkV("length", (cyc == 4 || cyc == 10) ? 16'h0002 :
        (cyc == 14) ? 16'h0004 : 16'h0003, {13'h0000, instLen});
    end
    // Short forms write just after done; let the write land
    repeat (2) @(negedge core_clk);
    got = sel == 0 ? far_u.regs[addr[7:0]] :
      sel == 1 ? far_u.progMem[addr] : far_u.dataMem[addr];
    checkV("value", {8'h00, expV}, {8'h00, got});
  endtask : step
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reg_forms();
    step(32'h0C10_0000, 4, 0, 16'h00C0, 8'h10);
    step(32'h0801_0000, 4, 0, 16'h00C0, 8'h20);
    step(32'h0801_0000, 4, 0, 16'h0001, 8'h20);
    step(32'h0901_0000, 4, 0, 16'h0001, 8'h01);
    step(32'hC710_0000, 4, 0, 16'h00C1, 8'h20);
    step(32'hD701_0000, 4, 0, 16'h0001, 8'h0A);
  endtask : t_reg_forms
  task automatic t_six_forms();
    step(32'hE401_0000, 6, 0, 16'h0000, 8'h20);
    step(32'hE500_0200, 6, 0, 16'h0002, 8'h20);
    step(32'hE600_0A00, 6, 0, 16'h0000, 8'h0A);
    step(32'hD600_1000, 6, 0, 16'h0001, 8'h10);
    step(32'hF502_0000, 6, 0, 16'h0001, 8'h02);
    step(32'h8701_3000, 6, 0, 16'h00C0, 8'hFF);
    step(32'h9710_3000, 6, 0, 16'h0031, 8'h0A);
  endtask : t_six_forms
  task automatic t_bit_load();
    step(32'h4724_3A00, 6, 0, 16'h00C2, 8'h07);
    step(32'h472B_0100, 6, 0, 16'h0001, 8'h00);
    step(32'h472B_0100, 6, 0, 16'h00C2, 8'h06);
  endtask : t_bit_load
  // Pair 0-1 is never used as a long offset pair here
  task automatic t_mem_read();
    step(32'hC304_0000, 10, 0, 16'h00C0, 8'h1A);
    step(32'hC305_0000, 10, 0, 16'h00C0, 8'h2A);
    step(32'hE704_0100, 12, 0, 16'h00C0, 8'h6D);
    step(32'hA704_0010, 14, 0, 16'h00C0, 8'h88);
    step(32'hA705_0010, 14, 0, 16'h00C0, 8'h98);
    step(32'hA700_0411, 14, 0, 16'h00C0, 8'h88);
    step(32'hA701_0411, 14, 0, 16'h00C0, 8'h98);
  endtask : t_mem_read
  task automatic t_mem_write();
    step(32'hD314_0000, 10, 1, 16'h0104, 8'h0A);
    step(32'hD315_0000, 10, 2, 16'h0104, 8'h0A);
    step(32'hF714_0100, 12, 1, 16'h0105, 8'h0A);
    step(32'hB714_0010, 14, 1, 16'h1104, 8'h0A);
    step(32'hB710_0511, 14, 1, 16'h1105, 8'h0A);
    step(32'hB711_0511, 14, 2, 16'h1105, 8'h0A);
  endtask : t_mem_write
  // Non-load opcode, then a start while busy that must be dropped
  task automatic t_refuse();
    step(32'hFF00_0000, 1, 0, 16'h00C0, 8'h01);
    checkV("illegal", 16'h0001, {15'h0000, sawIllegal});
    fork
      step(32'hC304_0000, 10, 0, 16'h00C0, 8'h1A);
      begin
        repeat (3) @(negedge core_clk);
        instStart = 1'b1;
        instByte0 = 8'h0C;
        @(negedge core_clk);
        instStart = 1'b0;
      end
    join
    repeat (8) @(negedge core_clk);
    checkV("idle", 16'h0000, {15'h0000, busy});
    checkV("kept", 16'h001A, {8'h00, far_u.regs[8'hC0]});
  endtask : t_refuse
  // Cut a hang short
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 4000) begin
      fails++;
      conclude();
    end
  end
  initial begin
    repeat (12) @(posedge core_clk);
    @(negedge core_clk);
    sys_rst = 1'b0;
    t_reg_forms();
    t_six_forms();
    t_bit_load();
    t_mem_read();
    t_mem_write();
    t_refuse();
    conclude();
  end
endmodule : load_instruction_group_decoder_tb_top
